// ---- src/prf_framer.sv ----
`default_nettype none
// Summary of operation
// - broadcast frames while disconnected and no switch node is reachable
// - space frames by pseudo random gaps, not a fixed period
// - first two alignment bits are zero
// - header type field is 1; receiver classifies frames by it
// - four reserved bits after the header type are zero
// - subnet field holds target base id; all ones means any subnet
// - address bytes go out from byte 0 (msb) to byte 5 (lsb)
// - requester field carries this station's own identifier
// - check byte covers the first 13 bytes, placed last
// - check is remainder of M(x)*x^8 by x^8+x^2+x+1, zero preset
// - header bits enter the check msb first
// - frames go to the phy with the most robust scheme
module prf_framer
  import prf_pkg::*;
#(
  parameter int GAP_MIN = GAP_MIN_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // mac side control
  input wire logic disconnected_i,
  input wire logic switch_seen_i,
  input wire logic [47:0] station_id_i,
  input wire logic [47:0] target_subnet_i,
  // phy transmit
  input wire logic tx_ready_i,
  output prf_pkg::prf_byte_t tx_o,
  output logic [1:0] tx_scheme_o,
  // phy receive
  input wire prf_pkg::prf_byte_t rx_i,
  // mac side receive report and transmit busy status
  output logic rx_done_o,
  output prf_pkg::prf_rx_info_t rx_info_o,
  output logic tx_busy_o
);
  import prf_pkg::*;

  typedef enum logic [1:0] {
    PRF_IDLE = 2'b00,
    PRF_SEND = 2'b01,
    PRF_WAIT = 2'b11
  } prf_state_t;

  prf_state_t state_r;
  prf_state_t state_nxt;
  logic [3:0] idx_r;
  logic [95:0] addr_r;
  prf_byte_t tx_r;
  logic busy_r;
  logic [7:0] tx_crc;
  logic [7:0] rx_crc;
  logic [3:0] rx_idx_r;
  logic [95:0] rx_addr_r;
  logic rx_bad_r;
  logic rx_done_r;
  prf_rx_info_t rx_info_r;
  logic [1:0] scheme_r;
  logic [3:0] idx_nxt;
  logic [95:0] addr_nxt;
  prf_byte_t tx_load;
  prf_byte_t tx_nxt;
  logic [3:0] rx_idx_nxt;
  logic [95:0] rx_addr_nxt;
  logic rx_bad_nxt;
  prf_rx_info_t rx_info_nxt;

  // ----------------------------------------------------------------
  // transmit byte selection
  // ----------------------------------------------------------------
  wire need_promo = disconnected_i && !switch_seen_i;
  wire gap_done;
  wire tx_take = !tx_r.valid || tx_ready_i;
  wire in_send = (state_r == PRF_SEND);
  wire load_byte = in_send && tx_take;
  wire [7:0] head_byte = {ALIGN_BITS, HT_PROMOTION, RESERVED_BITS};
  wire is_head = (idx_r == 4'h0);
  wire is_hcs = (idx_r == 4'(HDR_BYTES));
  wire [7:0] addr_byte = addr_r[95:88];
  wire [7:0] cur_byte = is_head ? head_byte :
                        (is_hcs ? tx_crc : addr_byte);
  wire hcs_step = load_byte && !is_hcs;
  wire last_taken = tx_r.valid && tx_r.last && tx_ready_i;

  prf_hcs u_tx_hcs (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clear_i(state_r == PRF_IDLE),
    .step_i(hcs_step),
    .byte_i(cur_byte),
    .crc_o(tx_crc)
  );

  prf_gap #(
    .GAP_MIN(GAP_MIN)
  ) u_gap (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(last_taken),
    .expired_o(gap_done)
  );

  // ----------------------------------------------------------------
  // transmit state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PRF_IDLE: begin
        if (need_promo) begin
          state_nxt = PRF_SEND;
        end
      end
      PRF_SEND: begin
        if (load_byte && is_hcs) begin
          state_nxt = PRF_WAIT;
        end
      end
      PRF_WAIT: begin
        if (gap_done && !tx_r.valid) begin
          state_nxt = PRF_IDLE;
        end
      end
      default: state_nxt = PRF_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // transmit next values
  // ----------------------------------------------------------------
  wire idx_clear = (state_r == PRF_IDLE);
  wire addr_shift = load_byte && !is_head;
  assign idx_nxt = idx_clear ? 4'h0 : (load_byte ? idx_r + 4'h1 : idx_r);
  assign addr_nxt = idx_clear ? {target_subnet_i, station_id_i} :
                    (addr_shift ? {addr_r[87:0], 8'h00} : addr_r);
  assign tx_load = '{data: cur_byte, valid: 1'b1, last: is_hcs};
  assign tx_nxt = load_byte ? tx_load : (tx_ready_i ? '0 : tx_r);

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= PRF_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // byte index
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      idx_r <= 4'h0;
    end else begin
      idx_r <= idx_nxt;
    end
  end

  // ----------------------------------------------------------------
  // address shift register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      addr_r <= '0;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // output byte
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tx_r <= '0;
    end else begin
      tx_r <= tx_nxt;
    end
  end

  // ----------------------------------------------------------------
  // busy status
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt != PRF_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // modulation scheme
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      scheme_r <= SCHEME_ROBUST;
    end else begin
      scheme_r <= SCHEME_ROBUST;
    end
  end

  // ----------------------------------------------------------------
  // receive check
  // ----------------------------------------------------------------
  wire rx_head = (rx_idx_r == 4'h0);
  wire rx_hcs = (rx_idx_r == 4'(HDR_BYTES));
  wire rx_step = rx_i.valid && !rx_hcs;
  wire [1:0] rx_ht = rx_i.data[HT_MSB:HT_LSB];
  wire rx_head_bad = (rx_ht != HT_PROMOTION);
  wire rx_end = rx_i.valid && (rx_hcs || rx_i.last);
  wire rx_ok = rx_hcs && !rx_bad_r && (rx_i.data == rx_crc);

  prf_hcs u_rx_hcs (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clear_i(rx_end),
    .step_i(rx_step),
    .byte_i(rx_i.data),
    .crc_o(rx_crc)
  );

  // ----------------------------------------------------------------
  // receive next values
  // ----------------------------------------------------------------
  wire rx_shift = !rx_end && !rx_head;
  assign rx_idx_nxt = rx_end ? 4'h0 : rx_idx_r + 4'h1;
  assign rx_bad_nxt = rx_end ? 1'b0 :
                      (rx_head ? rx_head_bad : rx_bad_r);
  assign rx_addr_nxt = rx_shift ? {rx_addr_r[87:0], rx_i.data} :
                       rx_addr_r;
  assign rx_info_nxt = '{subnet: rx_addr_r[95:48],
                         requester: rx_addr_r[47:0],
                         good: rx_ok};

  // ----------------------------------------------------------------
  // receive byte index
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_idx_r <= 4'h0;
    end else if (rx_i.valid) begin
      rx_idx_r <= rx_idx_nxt;
    end
  end

  // ----------------------------------------------------------------
  // receive header flag
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_bad_r <= 1'b0;
    end else if (rx_i.valid) begin
      rx_bad_r <= rx_bad_nxt;
    end
  end

  // ----------------------------------------------------------------
  // receive address shift register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_addr_r <= '0;
    end else if (rx_i.valid) begin
      rx_addr_r <= rx_addr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // receive done pulse
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= rx_end;
    end
  end

  // ----------------------------------------------------------------
  // receive report
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_info_r <= '0;
    end else if (rx_end) begin
      rx_info_r <= rx_info_nxt;
    end
  end

  // ----------------------------------------------------------------
  // output ports
  // ----------------------------------------------------------------
  assign tx_o = tx_r;
  assign tx_scheme_o = scheme_r;
  assign tx_busy_o = busy_r;
  assign rx_done_o = rx_done_r;
  assign rx_info_o = rx_info_r;
endmodule
`default_nettype wire

// ---- src/prf_pkg.sv ----
`default_nettype none
package prf_pkg;
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BYTES = 14;
  localparam int HDR_BYTES = 13;
  localparam logic [1:0] ALIGN_BITS = 2'h0;
  localparam logic [1:0] HT_PROMOTION = 2'h1;
  localparam logic [3:0] RESERVED_BITS = 4'h0;
  localparam logic [47:0] SNA_ANY = 48'hffff_ffff_ffff;
  localparam int HT_MSB = 5;
  localparam int HT_LSB = 4;
  localparam int ALIGN_MSB = 7;
  localparam int ALIGN_LSB = 6;
  localparam int RSV_MSB = 3;
  localparam int RSV_LSB = 0;
  // ----------------------------------------------------------------
  // check byte
  // ----------------------------------------------------------------
  localparam logic [7:0] HCS_POLY = 8'h07;
  localparam logic [7:0] HCS_INIT = 8'h00;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int GAP_MIN_CYC = 256;
  localparam int LFSR_W = 16;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  localparam logic [1:0] SCHEME_ROBUST = 2'h0;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic last;
  } prf_byte_t;

  typedef struct packed {
    logic [47:0] subnet;
    logic [47:0] requester;
    logic good;
  } prf_rx_info_t;
endpackage
`default_nettype wire

// ---- src/prf_hcs.sv ----
`default_nettype none
module prf_hcs
  import prf_pkg::*;
(
  // control
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic step_i,
  input wire logic [7:0] byte_i,
  // result
  output logic [7:0] crc_o
);
  import prf_pkg::*;
  logic [7:0] crc_r;
  logic [7:0] crc_nxt;

  // ----------------------------------------------------------------
  // bytewise division, msb first
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] c;
    c = crc_r ^ byte_i;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ HCS_POLY) : (c << 1);
    end
    crc_nxt = c;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || clear_i) begin
      crc_r <= HCS_INIT;
    end else if (step_i) begin
      crc_r <= crc_nxt;
    end
  end

  assign crc_o = crc_r;
endmodule
`default_nettype wire

// ---- src/prf_gap.sv ----
`default_nettype none
module prf_gap
  import prf_pkg::*;
#(
  parameter int GAP_MIN = GAP_MIN_CYC
) (
  // control
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  // status
  output logic expired_o
);
  import prf_pkg::*;
  logic [LFSR_W-1:0] lfsr_r;
  logic [LFSR_W:0] cnt_r;
  wire fb = ^(lfsr_r & LFSR_TAPS);

  // ----------------------------------------------------------------
  // pseudo random wait between frames
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lfsr_r <= LFSR_SEED;
      cnt_r <= '0;
    end else begin
      lfsr_r <= {lfsr_r[LFSR_W-2:0], fb};
      if (start_i) begin
        cnt_r <= (LFSR_W+1)'(GAP_MIN) + {1'b0, 4'h0, lfsr_r[11:0]};
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign expired_o = (cnt_r == '0);
endmodule
`default_nettype wire

// ---- sim/prf_framer_props.sv ----
`default_nettype none
module prf_framer_props
  import prf_pkg::*;
#(
  parameter int GAP_MIN = GAP_MIN_CYC
) (
  // watched ports
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic disconnected_i,
  input wire logic switch_seen_i,
  input wire logic [47:0] station_id_i,
  input wire logic [47:0] target_subnet_i,
  input wire logic tx_ready_i,
  input wire prf_pkg::prf_byte_t tx_o,
  input wire logic [1:0] tx_scheme_o,
  input wire prf_pkg::prf_byte_t rx_i,
  input wire logic rx_done_o,
  input wire prf_pkg::prf_rx_info_t rx_info_o,
  input wire logic tx_busy_o
);
  // ----
  // framing checks
  // ----
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_end;
    tx_o.valid && tx_o.last && tx_ready_i;
  endsequence
  sequence s_want;
    !tx_busy_o && disconnected_i && !switch_seen_i;
  endsequence
  property p_scheme;
    tx_scheme_o == SCHEME_ROBUST;
  endproperty
  a_scheme: assert property (p_scheme)
    else $error("scheme not robust");
  property p_hold;
    tx_o.valid && !tx_ready_i |=> $stable(tx_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("tx byte changed while stalled");
  property p_head;
    $rose(tx_o.valid) |-> tx_o.data == 8'h10;
  endproperty
  a_head: assert property (p_head)
    else $error("first byte wrong");
  property p_gap;
    s_end |=> !tx_o.valid [*4];
  endproperty
  a_gap: assert property (p_gap)
    else $error("no gap after frame");
  property p_start;
    s_want |-> ##[1:3] tx_o.valid;
  endproperty
  a_start: assert property (p_start)
    else $error("frame not started");
  property p_quiet;
    !disconnected_i && !tx_busy_o |=> !tx_o.valid;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("frame sent while connected");
  property p_pulse;
    rx_done_o |=> !rx_done_o;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("rx done not a pulse");
  property p_info;
    !rx_done_o |-> $stable(rx_info_o);
  endproperty
  a_info: assert property (p_info)
    else $error("rx info changed without done");
endmodule
bind prf_framer prf_framer_props #(.GAP_MIN(GAP_MIN)) u_props (
  .mclk_i(mclk_i), .rst_i(rst_i), .disconnected_i(disconnected_i),
  .switch_seen_i(switch_seen_i), .station_id_i(station_id_i),
  .target_subnet_i(target_subnet_i), .tx_ready_i(tx_ready_i),
  .tx_o(tx_o), .tx_scheme_o(tx_scheme_o), .rx_i(rx_i),
  .rx_done_o(rx_done_o), .rx_info_o(rx_info_o), .tx_busy_o(tx_busy_o));
`default_nettype wire

// ---- sim/prf_phy_model.sv ----
`default_nettype none
module prf_phy_model (
  // phy side
  input wire logic mclk_i,
  input wire logic rst_i,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int s = 80448;
  // random stalls of the transmit path
  initial tx_ready_o = 1'b0;
  always @(posedge mclk_i) tx_ready_o <= !rst_i && ($random(s) % 4 != 0);
endmodule
`default_nettype wire

// ---- sim/prf_framer_bench.sv ----
`default_nettype none
module prf_framer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import prf_pkg::*;
  localparam int GAP = 4;
  logic mclk_i = 0, rst_i = 1, disconnected_i = 0, switch_seen_i = 0;
  logic tx_ready_i, rx_done_o, tx_busy_o;
  logic [47:0] station_id_i, target_subnet_i;
  logic [1:0] tx_scheme_o;
  prf_byte_t tx_o, rx_i;
  prf_rx_info_t rx_info_o;
  int num_errors = 0, checked = 0, seed = 80448, cyc = 0, t0, tend, pe;
  int g[4];
  logic [7:0] fb[14];
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;
  prf_framer #(.GAP_MIN(GAP)) u_prf_framer (
    .mclk_i(mclk_i), .rst_i(rst_i), .disconnected_i(disconnected_i),
    .switch_seen_i(switch_seen_i), .station_id_i(station_id_i),
    .target_subnet_i(target_subnet_i), .tx_ready_i(tx_ready_i),
    .tx_o(tx_o), .tx_scheme_o(tx_scheme_o), .rx_i(rx_i),
    .rx_done_o(rx_done_o), .rx_info_o(rx_info_o), .tx_busy_o(tx_busy_o));
  prf_phy_model u_prf_phy_model (
    .mclk_i(mclk_i), .rst_i(rst_i), .tx_ready_o(tx_ready_i));
  // ----
  // model and helpers
  // ----
  task automatic chk(string n, logic [47:0] e, logic [47:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] crc8(int n);
    logic [7:0] c = 8'h00;
    for (int i = 0; i < n; i++)
      for (int k = 7; k >= 0; k--)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ fb[i][k]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic build(logic [47:0] sn, logic [47:0] rq);
    fb[0] = 8'h10;
    for (int k = 0; k < 6; k++) begin
      fb[1 + k] = sn[47 - 8 * k -: 8];
      fb[7 + k] = rq[47 - 8 * k -: 8];
    end
    fb[13] = crc8(13);
  endtask
  task automatic get_frame(bit drop);
    int i = 0;
    for (int n = 0; n < 6000 && i < 14; n++) begin
      @(posedge mclk_i);
      #1;
      if (tx_o.valid === 1'b1 && tx_ready_i === 1'b1) begin
        if (i == 0) t0 = cyc;
        chk("tx_byte", fb[i], tx_o.data);
        chk("tx_last", i == 13, tx_o.last);
        i++;
        if (drop) disconnected_i = 0;
      end
    end
    chk("tx_count", 14, i);
    tend = cyc;
  endtask
  task automatic send_rx(int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i);
      #1 rx_i = '{data: fb[i], valid: 1'b1, last: i == n - 1};
    end
    @(posedge mclk_i);
    #1 rx_i = '{data: ~rx_i.data, valid: 1'b0, last: 1'b0};
    for (int w = 0; w < 4 && rx_done_o !== 1'b1; w++) begin
      @(posedge mclk_i);
      #1;
    end
    chk("rx_done", 1, rx_done_o);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    rx_i = '0;
    station_id_i = 48'({$random(seed), $random(seed)});
    target_subnet_i = 48'({$random(seed), $random(seed)});
    repeat (4) @(posedge mclk_i);
    #1 rst_i = 0;
    repeat (20) @(posedge mclk_i);
    #1 chk("busy_connected", 0, tx_busy_o);
    disconnected_i = 1;
    switch_seen_i = 1;
    repeat (20) @(posedge mclk_i);
    #1 chk("busy_switch", 0, tx_busy_o);
    for (int c = 0; c < 4; c++) begin
      build(target_subnet_i, station_id_i);
      if (c == 1) fb[13] = ~fb[13];
      if (c == 2) fb[0] = 8'h20;
      if (c == 2) fb[13] = crc8(13);
      send_rx(c == 3 ? 10 : 14);
      chk("rx_good", c == 0, rx_info_o.good);
      if (c == 0) chk("rx_sub", target_subnet_i, rx_info_o.subnet);
      if (c == 0) chk("rx_req", station_id_i, rx_info_o.requester);
    end
    switch_seen_i = 0;
    for (int f = 0; f < 4; f++) begin
      pe = tend;
      build(target_subnet_i, station_id_i);
      get_frame(f == 3);
      g[f] = t0 - pe;
      target_subnet_i = SNA_ANY;
      chk("tx_scheme", 0, tx_scheme_o);
    end
    for (int f = 1; f < 4; f++) chk("gap_min", 1, g[f] > GAP);
    chk("gap_vary", 1, g[1] != g[2]);
    repeat (4300) @(posedge mclk_i);
    #1 chk("tx_stop", 0, tx_busy_o);
    print_verdict;
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    num_errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
